// file: design/cmpec_defines.svh
// Purpose: offsets, field positions and reset values of the comparator
//   control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef CMPEC_DEFINES_SVH
`define CMPEC_DEFINES_SVH

`define CMPEC_NUM_CMP 3
`define CMPEC_ADDR_W 8
// per comparator: control, mode, input mux; stride between comparators; then the one shared reset source register
`define CMPEC_OFF_CTRL 8'h00
`define CMPEC_OFF_MODE 8'h04
`define CMPEC_OFF_MUX 8'h08
`define CMPEC_CMP_STRIDE 8'h10
`define CMPEC_OFF_RSTSRC 8'h30
// control register fields
`define CMPEC_CTRL_EN 7
`define CMPEC_CTRL_OUT 6
`define CMPEC_CTRL_RISE 5
`define CMPEC_CTRL_FALL 4
`define CMPEC_CTRL_HYP_LSB 2
`define CMPEC_CTRL_HYN_LSB 0
// mode register fields
`define CMPEC_MODE_RIE 5
`define CMPEC_MODE_FIE 4
`define CMPEC_MODE_MD_LSB 0
// input mux register fields
`define CMPEC_MUX_NEG_LSB 4
`define CMPEC_MUX_POS_LSB 0
// reset values
`define CMPEC_RST_MODE_SEL 2'h2
`define CMPEC_RST_HYST 2'h0
`define CMPEC_RST_INSEL 2'h0

`endif

// file: design/cmpec_pkg.sv
// Purpose: types for the comparator control block
// Assumes: nothing beyond the defines header
// Notes: one struct per comparator for analog-facing controls
package cmpec_pkg;

  typedef struct packed {
    logic power_on;
    logic [1:0] response_sel;
    logic [1:0] pos_hyst_sel;
    logic [1:0] neg_hyst_sel;
    logic [1:0] pos_input_sel;
    logic [1:0] neg_input_sel;
  } cmpec_ana_ctl_t;

  typedef struct packed {
    logic cmp_on;
    logic rise_seen_flag;
    logic fall_seen_flag;
    logic [1:0] pos_hyst_sel;
    logic [1:0] neg_hyst_sel;
    logic rise_irq_en;
    logic fall_irq_en;
    logic [1:0] response_sel;
    logic [1:0] pos_input_sel;
    logic [1:0] neg_input_sel;
  } cmpec_cfg_t;

endpackage

// file: design/cmpec_top.sv
// Purpose: register, flag and output logic around three analog comparators
// Assumes: APB slave on mclk; raw comparator results are asynchronous
// Notes: raw outputs are purely combinational so they work with mclk off
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "cmpec_defines.svh"

// Function
// R01: three identical comparators; only comparator zero feeds a reset source.
// R02: each comparator has a clocked latched output and an unclocked raw output.
// R03: raw output follows comparator result even with the system clock stopped.
// R04: two-bit positive input select and two-bit negative input select each.
// R05: disabled comparator drives pin outputs low and has its power removed.
// R06: response time chosen by software in mode register; slower saves power.
// R07: independent positive and negative hysteresis fields, each can be off.
// R08: high-to-low output change sets the falling-edge flag.
// R09: low-to-high output change sets the rising-edge flag.
// R10: edge flags stay set until software writes zero to them.
// R11: reading the output status bit returns the present output level.
// R12: enable bit one turns comparator on, zero turns it off.
// R13: interrupt may come from rising edge, falling edge or both.
// R14: software should clear edge flags shortly after enabling or retuning.
// R15: control register bits: 7 enable, 6 output, 5 rise flag, 4 fall flag.
// R16: mode register bit 5 rise interrupt enable, bit 4 fall, reset zero.
// R17: response mode 0 fastest through 3 slowest; reset selects mode 2.
// R18: hysteresis code 00 off, 01 to 11 increasing amounts.
// R19: interrupt request held while a flag and its enable are both set.
// R20: raw result passes two flip-flops; edges detected on synchronised value.
module cmpec_top
  import cmpec_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cmp_result,
  output cmpec_ana_ctl_t [2:0] ana_ctl,
  output logic [2:0] raw_out,
  output logic [2:0] latched_out,
  output logic [2:0] cmp_irq,
  output logic cmp0_reset_req
);

  localparam int N = `CMPEC_NUM_CMP;

  cmpec_cfg_t [N-1:0] cfg_r;
  cmpec_cfg_t [N-1:0] cfg_nxt;
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] prev_r;
  logic [N-1:0] sync_nxt;
  logic [N-1:0] latched_r;
  logic [N-1:0] latched_nxt;
  logic [N-1:0] irq_r;
  logic [N-1:0] irq_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic rst_en_r;
  logic rst_en_nxt;
  logic rst_req_r;
  logic rst_req_nxt;
  logic [7:0] addr;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic in_range;
  logic wr_en;
  logic sel_rstsrc;
  logic [N-1:0] sel_ctrl;
  logic [N-1:0] sel_mode;
  logic [N-1:0] sel_mux;
  logic [N-1:0] rise_ev;
  logic [N-1:0] fall_ev;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;

  assign addr = paddr[7:0];
  // any upper address bit set makes the access unmapped
  assign in_range = (paddr[31:8] == 24'h0);
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  // every register sits in byte lane zero
  assign wr_en = wr_acc & pstrb[0];
  assign pready = 1'b1;
  assign sel_rstsrc = in_range & (addr == `CMPEC_OFF_RSTSRC);

  // one address match per comparator and register
  for (genvar g = 0; g < N; g++)
  begin : g_dec
    assign sel_ctrl[g] = in_range &
      (addr == 8'(`CMPEC_OFF_CTRL + g * `CMPEC_CMP_STRIDE));
    assign sel_mode[g] = in_range &
      (addr == 8'(`CMPEC_OFF_MODE + g * `CMPEC_CMP_STRIDE));
    assign sel_mux[g] = in_range &
      (addr == 8'(`CMPEC_OFF_MUX + g * `CMPEC_CMP_STRIDE));
  end

  // raw path: combinational gate only, no clock involved
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      raw_out[i] = cmp_result[i] & cfg_r[i].cmp_on; // R02 R03 R05
    end
  end

  // analog-facing controls
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      ana_ctl[i].power_on = cfg_r[i].cmp_on; // R05 R12
      ana_ctl[i].response_sel = cfg_r[i].response_sel; // R06 R17
      ana_ctl[i].pos_hyst_sel = cfg_r[i].pos_hyst_sel; // R07 R18
      ana_ctl[i].neg_hyst_sel = cfg_r[i].neg_hyst_sel; // R07 R18
      ana_ctl[i].pos_input_sel = cfg_r[i].pos_input_sel; // R04
      ana_ctl[i].neg_input_sel = cfg_r[i].neg_input_sel; // R04
    end
  end

  // synchroniser and edge history
  always_comb
  begin
    sync_nxt = cmp_result & {cfg_r[2].cmp_on, cfg_r[1].cmp_on,
      cfg_r[0].cmp_on};
    latched_nxt = sync2_r; // R02 R05
    // comparator zero may reset the chip only once its chain has refilled
    if (!cfg_r[0].cmp_on)
    begin
      settle_nxt = 2'h0;
    end
    else if (!settle_r[1])
    begin
      settle_nxt = settle_r + 2'h1;
    end
    else
    begin
      settle_nxt = settle_r;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r <= 3'h0;
      latched_r <= 3'h0;
      settle_r <= 2'h0;
    end
    else
    begin
      sync1_r <= sync_nxt; // R20
      sync2_r <= sync1_r; // R20
      prev_r <= sync2_r;
      latched_r <= latched_nxt;
      settle_r <= settle_nxt;
    end
  end

  assign latched_out = latched_r;

  // edges are taken from the synchronised value only
  assign rise_ev = sync2_r & ~prev_r; // R09 R20
  assign fall_ev = ~sync2_r & prev_r; // R08 R20

  // register writes, flags and interrupt requests
  always_comb
  begin
    cfg_nxt = cfg_r;
    rst_en_nxt = rst_en_r;
    for (int i = 0; i < N; i++)
    begin
      if (wr_en && sel_ctrl[i])
      begin
        cfg_nxt[i].cmp_on = pwdata[`CMPEC_CTRL_EN]; // R12 R15
        // write of zero clears, write of one leaves the flag alone
        if (!pwdata[`CMPEC_CTRL_RISE])
        begin
          cfg_nxt[i].rise_seen_flag = 1'b0; // R10
        end
        if (!pwdata[`CMPEC_CTRL_FALL])
        begin
          cfg_nxt[i].fall_seen_flag = 1'b0; // R10
        end
        cfg_nxt[i].pos_hyst_sel = pwdata[`CMPEC_CTRL_HYP_LSB +: 2]; // R07
        cfg_nxt[i].neg_hyst_sel = pwdata[`CMPEC_CTRL_HYN_LSB +: 2]; // R07
      end
      else if (wr_en && sel_mode[i])
      begin
        cfg_nxt[i].rise_irq_en = pwdata[`CMPEC_MODE_RIE]; // R16
        cfg_nxt[i].fall_irq_en = pwdata[`CMPEC_MODE_FIE]; // R16
        cfg_nxt[i].response_sel = pwdata[`CMPEC_MODE_MD_LSB +: 2]; // R06
      end
      else if (wr_en && sel_mux[i])
      begin
        cfg_nxt[i].pos_input_sel = pwdata[`CMPEC_MUX_POS_LSB +: 2]; // R04
        cfg_nxt[i].neg_input_sel = pwdata[`CMPEC_MUX_NEG_LSB +: 2]; // R04
      end
      // edge set wins over a same-cycle clear
      if (rise_ev[i])
      begin
        cfg_nxt[i].rise_seen_flag = 1'b1; // R09 R20
      end
      if (fall_ev[i])
      begin
        cfg_nxt[i].fall_seen_flag = 1'b1; // R08 R20
      end
      irq_nxt[i] = (cfg_nxt[i].rise_seen_flag & cfg_nxt[i].rise_irq_en) |
        (cfg_nxt[i].fall_seen_flag & cfg_nxt[i].fall_irq_en); // R13 R19
    end
    if (wr_en && sel_rstsrc)
    begin
      rst_en_nxt = pwdata[0];
    end
    // only comparator zero can request a reset, when low and enabled,
    // and only after its chain holds samples taken while enabled
    rst_req_nxt = rst_en_nxt & cfg_nxt[0].cmp_on & ~sync2_r[0] &
      settle_r[1]; // R01
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < N; i++)
      begin
        cfg_r[i] <= '{cmp_on: 1'b0, rise_seen_flag: 1'b0,
          fall_seen_flag: 1'b0, pos_hyst_sel: `CMPEC_RST_HYST,
          neg_hyst_sel: `CMPEC_RST_HYST, rise_irq_en: 1'b0,
          fall_irq_en: 1'b0, response_sel: `CMPEC_RST_MODE_SEL, // R17
          pos_input_sel: `CMPEC_RST_INSEL,
          neg_input_sel: `CMPEC_RST_INSEL};
      end
      irq_r <= 3'h0;
      rst_en_r <= 1'b0;
      rst_req_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      irq_r <= irq_nxt;
      rst_en_r <= rst_en_nxt;
      rst_req_r <= rst_req_nxt;
    end
  end

  assign cmp_irq = irq_r;
  assign cmp0_reset_req = rst_req_r;

  // read mux, registered on the setup phase for data in access phase
  always_comb
  begin
    prdata_nxt = 32'h0;
    hit = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      if (sel_ctrl[i])
      begin
        hit = 1'b1;
        prdata_nxt[`CMPEC_CTRL_EN] = cfg_r[i].cmp_on;
        prdata_nxt[`CMPEC_CTRL_OUT] = sync2_r[i]; // R11 R15
        prdata_nxt[`CMPEC_CTRL_RISE] = cfg_r[i].rise_seen_flag;
        prdata_nxt[`CMPEC_CTRL_FALL] = cfg_r[i].fall_seen_flag;
        prdata_nxt[`CMPEC_CTRL_HYP_LSB +: 2] = cfg_r[i].pos_hyst_sel;
        prdata_nxt[`CMPEC_CTRL_HYN_LSB +: 2] = cfg_r[i].neg_hyst_sel;
      end
      else if (sel_mode[i])
      begin
        hit = 1'b1;
        prdata_nxt[`CMPEC_MODE_RIE] = cfg_r[i].rise_irq_en;
        prdata_nxt[`CMPEC_MODE_FIE] = cfg_r[i].fall_irq_en;
        prdata_nxt[`CMPEC_MODE_MD_LSB +: 2] = cfg_r[i].response_sel;
      end
      else if (sel_mux[i])
      begin
        hit = 1'b1;
        prdata_nxt[`CMPEC_MUX_POS_LSB +: 2] = cfg_r[i].pos_input_sel;
        prdata_nxt[`CMPEC_MUX_NEG_LSB +: 2] = cfg_r[i].neg_input_sel;
      end
    end
    if (sel_rstsrc)
    begin
      hit = 1'b1;
      prdata_nxt[0] = rst_en_r;
    end
    if (paddr[31:8] != 24'h0)
    begin
      hit = 1'b0;
      prdata_nxt = 32'h0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_r <= 32'h0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = rd_acc ? prdata_r : 32'h0;
  assign pslverr = psel & penable & ~hit;

endmodule

// file: tb/cmpec_props.sv
// Purpose: port checker for cmpec_top
// Assumes: bound to every cmpec_top
// Notes: comparator 0 watched in depth
`timescale 1ns/1ps
module cmpec_props
  import cmpec_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic [2:0] cmp_result,
  input wire cmpec_ana_ctl_t [2:0] ana_ctl,
  input wire logic [2:0] raw_out,
  input wire logic [2:0] latched_out,
  input wire logic [2:0] cmp_irq,
  input wire logic cmp0_reset_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire wr = psel & penable & pwrite & pstrb[0];
  wire [2:0] pw = {ana_ctl[2].power_on, ana_ctl[1].power_on,
    ana_ctl[0].power_on};
  a_raw_gated:
    assert property (raw_out == (cmp_result & pw))
    else $error("raw output not gated");
  a_off_quiet:
    assert property ((!pw[1]) [*4] |-> !latched_out[1])
    else $error("disabled output not low");
  a_sync_delay:
    assert property (latched_out == $past(raw_out, 3))
    else $error("latched output delay wrong");
  a_ctrl_write:
    assert property (wr && paddr == 32'h0 |=> {pw[0],
      ana_ctl[0].pos_hyst_sel, ana_ctl[0].neg_hyst_sel} ==
      {$past(pwdata[7]), $past(pwdata[3:0])})
    else $error("control write lost");
  a_mode_write:
    assert property (wr && paddr == 32'h4 |=>
      ana_ctl[0].response_sel == $past(pwdata[1:0]))
    else $error("mode write lost");
  a_mux_write:
    assert property (wr && paddr == 32'h8 |=> {ana_ctl[0].pos_input_sel,
      ana_ctl[0].neg_input_sel} == {$past(pwdata[1:0]), $past(pwdata[5:4])})
    else $error("input select write lost");
  a_irq_cause:
    assert property ($rose(cmp_irq[0]) |-> $changed(latched_out[0]) ||
      $past(wr) || $past(wr, 2))
    else $error("interrupt without cause");
  a_irq_held:
    assert property ($fell(cmp_irq[0]) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt dropped alone");
  a_reset_cause:
    assert property (cmp0_reset_req |-> pw[0] && !latched_out[0])
    else $error("reset request without cause");
  c_reset: cover property ($rose(cmp0_reset_req));
  c_rise: cover property ($rose(cmp_irq[0]));
  c_fall: cover property ($fell(latched_out[0]));
  c_err: cover property (pslverr);
endmodule
bind cmpec_top cmpec_props i_props (.*);

// file: tb/cmpec_ana_model.sv
// Purpose: behavioural analog comparator core
// Assumes: target is the ideal comparison result
// Notes: unpowered core shows the inverse level
`timescale 1ns/1ps
module cmpec_ana_model
  import cmpec_pkg::*;
(
  input wire logic mclk,
  input wire cmpec_ana_ctl_t [2:0] ana_ctl,
  input wire logic [2:0] target,
  output logic [2:0] cmp_result
);
  logic [2:0] d1 = 3'h0;
  logic [2:0] d2 = 3'h0;
  logic [2:0] d3 = 3'h0;
  wire [11:0] h = {d3, d2, d1, target};
  always @(posedge mclk)
  begin
    d1 <= target;
    d2 <= d1;
    d3 <= d2;
  end
  // slower response codes take an older sample
  always_comb
    for (int i = 0; i < 3; i++)
      cmp_result[i] = ana_ctl[i].power_on ?
        h[3 * ana_ctl[i].response_sel + i] : ~target[i];
endmodule

// file: tb/comparator_edge_control_tb.sv
// Purpose: register and edge-flag tests of cmpec_top
// Assumes: zero wait states are not relied on
// Notes: flags are checked through the control register
`timescale 1ns/1ps
module comparator_edge_control_tb
  import cmpec_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] target = 3'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serr, cmp0_reset_req;
  logic [2:0] cmp_result, raw_out, latched_out, cmp_irq;
  cmpec_ana_ctl_t [2:0] ana_ctl;
  logic [7:0] rdat;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 mclk = ~mclk;
  cmpec_top i_dut (.*);
  cmpec_ana_model i_ana (.*);
  task end_of_test;
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && cyc < 4000)
      @(posedge mclk);
    rdat = prdata[7:0];
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h0);
    chk("register read", e, rdat);
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (logic [7:0] b = 0; b < 8'h30; b += 8'h10)
    begin
      rd(b, 8'h00);
      rd(b + 8'h04, 8'h02);
      rd(b + 8'h08, 8'h00);
      for (logic [7:0] k = 0; k < 8'h4; k++)
      begin
        apb(1'b1, b, 8'h80 | k * 8'h5);
        rd(b, 8'h80 | k * 8'h5);
        apb(1'b1, b + 8'h04, k);
        rd(b + 8'h04, k);
        apb(1'b1, b + 8'h08, k | k << 4);
        rd(b + 8'h08, k | k << 4);
      end
    end
    apb(1'b1, 8'h04, 8'h30);
    target <= 3'h1;
    #1 chk("raw output", 8'h01, {7'h0, raw_out[0]});
    repeat (6) @(posedge mclk);
    rd(8'h00, 8'hef);
    chk("interrupt", 8'h01, {7'h0, cmp_irq[0]});
    target <= 3'h0;
    repeat (6) @(posedge mclk);
    rd(8'h00, 8'hbf);
    apb(1'b1, 8'h00, 8'h8f);
    rd(8'h00, 8'h8f);
    chk("interrupt", 8'h00, {7'h0, cmp_irq[0]});
    apb(1'b1, 8'h00, 8'h00);
    target <= 3'h1;
    #1 chk("raw output", 8'h00, {7'h0, raw_out[0]});
    repeat (6) @(posedge mclk);
    rd(8'h00, 8'h00);
    apb(1'b0, 8'h0c, 8'h00);
    chk("slave error", 8'h01, {7'h0, serr});
    chk("unmapped data", 8'h00, rdat);
    pstrb <= 4'h0;
    apb(1'b1, 8'h04, 8'h00);
    pstrb <= 4'hf;
    rd(8'h04, 8'h30);
    apb(1'b1, 8'h30, 8'h01);
    rd(8'h30, 8'h01);
    apb(1'b1, 8'h04, 8'h20);
    apb(1'b1, 8'h00, 8'h80);
    repeat (6) @(posedge mclk);
    chk("reset request", 8'h00, {7'h0, cmp0_reset_req});
    chk("interrupt", 8'h01, {7'h0, cmp_irq[0]});
    apb(1'b1, 8'h00, 8'h80);
    target <= 3'h0;
    repeat (6) @(posedge mclk);
    chk("interrupt", 8'h00, {7'h0, cmp_irq[0]});
    chk("reset request", 8'h01, {7'h0, cmp0_reset_req});
    rd(8'h00, 8'h90);
    apb(1'b1, 8'h30, 8'h00);
    chk("reset request", 8'h00, {7'h0, cmp0_reset_req});
    end_of_test;
  end
endmodule
